// [hw/gpc_pkg.sv]
package gpc_pkg;
    localparam int        GPC_W           = 8;
    localparam logic [11:0] ADDR_PORT_B   = 12'h000;
    localparam logic [11:0] ADDR_DIR_B    = 12'h004;
    localparam logic [11:0] ADDR_ANALOG_SELECT_LOW_H  = 12'h008;
    localparam logic [11:0] ADDR_PULL_UP  = 12'h00C;
    localparam logic [11:0] ADDR_CHG_EN   = 12'h010;
    localparam logic [11:0] ADDR_INT_CTRL = 12'h014;
    localparam logic [11:0] ADDR_OPTION   = 12'h018;
    localparam logic [11:0] ADDR_PORT_A   = 12'h01C;
    localparam logic [11:0] ADDR_DIR_A    = 12'h020;
    localparam logic [11:0] ADDR_ANALOG_SELECT_LOW_L  = 12'h024;
    localparam logic [7:0]  RST_ONES      = 8'hFF;
    localparam logic [7:0]  RST_ZERO      = 8'h00;
    localparam logic [7:0]  RST_OPTION    = 8'hFF;
    localparam int          OPT_PU_OFF_N  = 7;
    localparam int          INT_FLAG_BIT  = 0;
    localparam int          INT_EN_BIT    = 3;
    localparam int          PA_INPUT_ONLY = 3;
endpackage : gpc_pkg

// [hw/gpc_sync.sv]
`timescale 1ns/1ps
// two-stage synchroniser, one per bit
module gpc_sync
    import gpc_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } gpc_sync_t;

    gpc_sync_t st;
    gpc_sync_t next_st;

    // only the second stage ever looks at the first
    always_comb begin
        next_st      = st;
        next_st.meta = d;
        next_st.q    = st.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign q = st.q;
endmodule : gpc_sync

// [hw/gpc_port.sv]
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// RULE_01: eight-pin port through one register
// RULE_02: direction one tristates, zero drives latch
// RULE_03: read gives pins, write hits latch
// RULE_04: writes are read-modify-write into latch
// RULE_05: software keeps analog pins as inputs
// RULE_06: analog-selected pins read as zero
// RULE_07: analog select leaves output drive alone
// RULE_08: per-pin weak pull-up enable
// RULE_09: output pins never get pull-up
// RULE_10: power-on reset disables all pull-ups
// RULE_11: per-pin change enable gates detection
// RULE_12: power-on reset clears change enables
// RULE_13: or of enabled mismatches sets flag
// RULE_14: change flag wakes device from sleep
// RULE_15: mismatch keeps flag; port access reloads
// RULE_16: last-read latch survives soft resets
// RULE_17: change coincident with read may miss
// RULE_18: first port bit three input only
// RULE_19: pull-ups need global off bit clear
// RULE_20: pull-up, analog reset one; enables zero
// RULE_21: software sequence for low-power wake
// RULE_22: pins synchronised before any use
// RULE_23: flag clear loses to live mismatch
module gpc_port
    import gpc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        soft_reset_n,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  port_b_in,
    output logic      [7:0]  port_b_out,
    output logic      [7:0]  port_b_oe_n,
    output logic      [7:0]  port_b_pull_up,
    input  wire logic [7:0]  port_a_in,
    output logic      [7:0]  port_a_out,
    output logic      [7:0]  port_a_oe_n,
    output logic             port_b_change_flag,
    output logic             wake_request
);
    typedef struct packed {
        logic [7:0]  port_b_latch;
        logic [7:0]  port_b_direction;
        logic [7:0]  analog_select_high;
        logic [7:0]  pull_up_enable_b;
        logic [7:0]  change_int_enable_b;
        logic [7:0]  option_config;
        logic [7:0]  port_a_latch;
        logic [7:0]  port_a_direction;
        logic [7:0]  analog_select_low;
        logic        change_int_on;
        logic        port_b_change_flag;
        logic [7:0]  last_read;
        logic [31:0] prdata;
    } gpc_state_t;

    gpc_state_t st;
    gpc_state_t next_st;
    logic [7:0] pins_b;
    logic [7:0] pins_a;
    logic [7:0] rd_b;
    logic [7:0] rd_a;
    logic [7:0] wr_mask;
    logic [7:0] mismatch_bits;
    logic       mismatch;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       port_b_touch;

    gpc_sync #(.W(GPC_W)) u_sync_b (                                   // [RULE_22]
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (clk_en),
        .d       (port_b_in),
        .q       (pins_b)
    );
    gpc_sync #(.W(GPC_W)) u_sync_a (                                   // [RULE_22]
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (clk_en),
        .d       (port_a_in),
        .q       (pins_a)
    );

    assign acc          = psel && penable && clk_en;
    assign wr           = acc && pwrite;
    assign rd           = acc && !pwrite;
    assign wr_mask      = pstrb[0] ? 8'hFF : 8'h00;
    assign port_b_touch = acc && (paddr == ADDR_PORT_B);               // [RULE_15]
    assign rd_b         = pins_b & ~st.analog_select_high;             // [RULE_03] [RULE_06]
    assign rd_a         = pins_a & ~st.analog_select_low;              // [RULE_06]
    assign mismatch_bits = (rd_b ^ st.last_read) & st.change_int_enable_b; // [RULE_11] [RULE_13]
    // compare uses the old last read; a change in the read cycle still sets the flag
    assign mismatch     = |mismatch_bits;                              // [RULE_17]

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = st.prdata;

    always_comb begin
        next_st = st;
        if (port_b_touch) begin
            next_st.last_read = rd_b;                                  // [RULE_15]
        end
        if (rd) begin
            case (paddr)
                ADDR_PORT_B:   next_st.prdata = {24'h00_0000, rd_b};   // [RULE_01] [RULE_03]
                ADDR_DIR_B:    next_st.prdata = {24'h00_0000, st.port_b_direction};
                ADDR_ANALOG_SELECT_LOW_H:  next_st.prdata = {24'h00_0000, st.analog_select_high};
                ADDR_PULL_UP:  next_st.prdata = {24'h00_0000, st.pull_up_enable_b};
                ADDR_CHG_EN:   next_st.prdata = {24'h00_0000, st.change_int_enable_b};
                ADDR_INT_CTRL: next_st.prdata = {24'h00_0000, 4'h0, st.change_int_on,
                                                 2'b00, st.port_b_change_flag};
                ADDR_OPTION:   next_st.prdata = {24'h00_0000, st.option_config};
                ADDR_PORT_A:   next_st.prdata = {24'h00_0000, rd_a};
                ADDR_DIR_A:    next_st.prdata = {24'h00_0000, st.port_a_direction};
                ADDR_ANALOG_SELECT_LOW_L:  next_st.prdata = {24'h00_0000, st.analog_select_low};
                default:       next_st.prdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            case (paddr)
                // latch takes pin view, then the written bits
                ADDR_PORT_B:   next_st.port_b_latch = (rd_b & ~wr_mask)
                                                    | (pwdata[7:0] & wr_mask); // [RULE_04]
                ADDR_DIR_B:    next_st.port_b_direction =
                                   (st.port_b_direction & ~wr_mask) | (pwdata[7:0] & wr_mask);
                ADDR_ANALOG_SELECT_LOW_H:  next_st.analog_select_high =
                                   (st.analog_select_high & ~wr_mask) | (pwdata[7:0] & wr_mask);
                ADDR_PULL_UP:  next_st.pull_up_enable_b =
                                   (st.pull_up_enable_b & ~wr_mask) | (pwdata[7:0] & wr_mask);
                ADDR_CHG_EN:   next_st.change_int_enable_b =
                                   (st.change_int_enable_b & ~wr_mask) | (pwdata[7:0] & wr_mask);
                ADDR_INT_CTRL: begin
                    if (pstrb[0]) begin
                        next_st.change_int_on = pwdata[INT_EN_BIT];
                        if (!pwdata[INT_FLAG_BIT]) begin
                            next_st.port_b_change_flag = 1'b0;
                        end
                    end
                end
                ADDR_OPTION:   next_st.option_config =
                                   (st.option_config & ~wr_mask) | (pwdata[7:0] & wr_mask);
                ADDR_PORT_A:   next_st.port_a_latch = (rd_a & ~wr_mask)
                                                    | (pwdata[7:0] & wr_mask); // [RULE_04]
                ADDR_DIR_A: begin
                    next_st.port_a_direction =
                        (st.port_a_direction & ~wr_mask) | (pwdata[7:0] & wr_mask);
                    next_st.port_a_direction[PA_INPUT_ONLY] = 1'b1;    // [RULE_18]
                end
                ADDR_ANALOG_SELECT_LOW_L:  next_st.analog_select_low =
                                   (st.analog_select_low & ~wr_mask) | (pwdata[7:0] & wr_mask);
                default: begin
                end
            endcase
        end
        if (mismatch) begin
            next_st.port_b_change_flag = 1'b1;                         // [RULE_13] [RULE_23]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.port_b_latch        <= RST_ZERO;
            st.port_b_direction    <= RST_ONES;
            st.analog_select_high  <= RST_ONES;                        // [RULE_20]
            st.pull_up_enable_b    <= RST_ONES;                        // [RULE_20]
            st.change_int_enable_b <= RST_ZERO;                        // [RULE_12] [RULE_20]
            st.option_config       <= RST_OPTION;                      // [RULE_10]
            st.port_a_latch        <= RST_ZERO;
            st.port_a_direction    <= RST_ONES;
            st.analog_select_low   <= RST_ONES;
            st.change_int_on       <= 1'b0;
            st.port_b_change_flag  <= 1'b0;
            st.last_read           <= RST_ZERO;
            st.prdata              <= 32'h0000_0000;
        end else if (!soft_reset_n) begin
            // soft reset: registers to defaults except change enables and last read, flag rebuilt from mismatch
            st.port_b_latch        <= RST_ZERO;
            st.port_b_direction    <= RST_ONES;
            st.analog_select_high  <= RST_ONES;
            st.pull_up_enable_b    <= RST_ONES;
            st.change_int_enable_b <= st.change_int_enable_b;
            st.option_config       <= RST_OPTION;
            st.port_a_latch        <= RST_ZERO;
            st.port_a_direction    <= RST_ONES;
            st.analog_select_low   <= RST_ONES;
            st.change_int_on       <= 1'b0;
            st.port_b_change_flag  <= mismatch;                        // [RULE_16]
            st.last_read           <= st.last_read;                    // [RULE_16]
            st.prdata              <= 32'h0000_0000;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign port_b_out     = st.port_b_latch;                           // [RULE_07]
    assign port_b_oe_n    = st.port_b_direction;                       // [RULE_02]
    assign port_b_pull_up = st.pull_up_enable_b & st.port_b_direction  // [RULE_08] [RULE_09]
                          & {GPC_W{~st.option_config[OPT_PU_OFF_N]}};  // [RULE_19]
    assign port_a_out     = st.port_a_latch;
    assign port_a_oe_n    = st.port_a_direction | (8'h01 << PA_INPUT_ONLY); // [RULE_18]
    assign port_b_change_flag = st.port_b_change_flag;
    assign wake_request   = st.port_b_change_flag && st.change_int_on; // [RULE_14]
endmodule : gpc_port

// [verification/gpc_port_properties.sv]
`timescale 1ns/1ps
module gpc_port_checker
    import gpc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        soft_reset_n,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [7:0]  port_b_out,
    input wire logic [7:0]  port_b_oe_n,
    input wire logic [7:0]  port_b_pull_up,
    input wire logic [7:0]  port_a_oe_n,
    input wire logic        port_b_change_flag,
    input wire logic        wake_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(logic [11:0] a);
        psel && penable && pwrite && clk_en && soft_reset_n && pstrb[0] && paddr == a;
    endsequence
    property p_wr_latch; s_wr(ADDR_PORT_B) |=> port_b_out == $past(pwdata[7:0]); endproperty
    property p_dir_b; s_wr(ADDR_DIR_B) |=> port_b_oe_n == $past(pwdata[7:0]); endproperty
    property p_dir_a; s_wr(ADDR_DIR_A) |=> port_a_oe_n == ($past(pwdata[7:0]) | 8'h08); endproperty
    property p_pull_out; (port_b_pull_up & ~port_b_oe_n) == 8'h00; endproperty
    property p_pa3; port_a_oe_n[PA_INPUT_ONLY]; endproperty
    property p_wake; wake_request |-> port_b_change_flag; endproperty
    property p_por_pull; $rose(presetn) |-> port_b_pull_up == 8'h00; endproperty
    property p_por_flag; $rose(presetn) |-> !port_b_change_flag && !wake_request; endproperty
    property p_flag_hold;
        port_b_change_flag && clk_en && soft_reset_n
            && !(psel && penable && pwrite && paddr == ADDR_INT_CTRL) |=> port_b_change_flag;
    endproperty
    a_wr_latch: assert property (p_wr_latch)
        else $error("latch differs from written byte");
    a_dir_b: assert property (p_dir_b)
        else $error("port b drivers differ from direction write");
    a_dir_a: assert property (p_dir_a)
        else $error("port a drivers differ from direction write");
    a_pull_out: assert property (p_pull_out)
        else $error("pull-up on while pin drives");
    a_pa3: assert property (p_pa3)
        else $error("port a bit three driven");
    a_wake: assert property (p_wake)
        else $error("wake without change flag");
    a_por_pull: assert property (p_por_pull)
        else $error("pull-up on after power-on reset");
    a_por_flag: assert property (p_por_flag)
        else $error("change flag set after power-on reset");
    a_flag_hold: assert property (p_flag_hold)
        else $error("change flag dropped without clear");
endmodule : gpc_port_checker

bind gpc_port gpc_port_checker i_gpc_port_checker (
    .pclk               (pclk),
    .presetn            (presetn),
    .soft_reset_n       (soft_reset_n),
    .clk_en             (clk_en),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pstrb              (pstrb),
    .port_b_out         (port_b_out),
    .port_b_oe_n        (port_b_oe_n),
    .port_b_pull_up     (port_b_pull_up),
    .port_a_oe_n        (port_a_oe_n),
    .port_b_change_flag (port_b_change_flag),
    .wake_request       (wake_request)
);

// [verification/gpc_pin_board.sv]
`timescale 1ns/1ps
// pins seen by the port; undriven pins without pull-up toggle every cycle
module gpc_pin_board (
    input  wire logic       pclk,
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe_n,
    input  wire logic [7:0] b_pull_up,
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_b_en,
    input  wire logic [7:0] a_out,
    input  wire logic [7:0] a_oe_n,
    input  wire logic [7:0] ext_a,
    output logic      [7:0] b_in,
    output logic      [7:0] a_in
);
    logic [7:0] flt = 8'h5A;
    always @(posedge pclk) flt <= ~flt;
    assign b_in = (~b_oe_n & b_out) | (b_oe_n & ext_b_en & ext_b)
                | (b_oe_n & ~ext_b_en & (b_pull_up | flt));
    assign a_in = (~a_oe_n & a_out) | (a_oe_n & ext_a);
endmodule : gpc_pin_board

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench
    import gpc_pkg::*;
;
    typedef struct { logic [7:0] lat, dir, ana, ext, rd; } gpc_row_t;
    logic        pclk, presetn, soft_reset_n, clk_en, psel, penable, pwrite;
    logic        pready, pslverr, flag, wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  b_out, b_oe_n, b_pu, b_in, ext_b, ext_b_en, a_out, a_oe_n, a_in, ext_a;
    int          errors, n_tests;
    gpc_row_t    rows[4] = '{'{8'h00, 8'hFF, 8'h00, 8'hA5, 8'hA5},
                             '{8'h00, 8'hFF, 8'h0F, 8'hFF, 8'hF0},
                             '{8'h3C, 8'h00, 8'h00, 8'h00, 8'h3C},
                             '{8'h3C, 8'h0F, 8'hF0, 8'h55, 8'h05}};
    logic [11:0] ra[5] = '{ADDR_DIR_B, ADDR_PULL_UP, ADDR_CHG_EN, ADDR_OPTION, ADDR_ANALOG_SELECT_LOW_H};
    logic [7:0]  rv[5] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF};

    gpc_port i_gpc_port (.pclk(pclk), .presetn(presetn), .soft_reset_n(soft_reset_n),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oe_n), .port_b_pull_up(b_pu),
        .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oe_n),
        .port_b_change_flag(flag), .wake_request(wake));
    gpc_pin_board i_gpc_pin_board (.pclk(pclk), .b_out(b_out), .b_oe_n(b_oe_n),
        .b_pull_up(b_pu), .ext_b(ext_b), .ext_b_en(ext_b_en), .a_out(a_out),
        .a_oe_n(a_oe_n), .ext_a(ext_a), .b_in(b_in), .a_in(a_in));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : tick

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        rd = prdata;
    endtask : apb

    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        wrap_up();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {soft_reset_n, clk_en, pstrb} = 6'b11_0001;
        {ext_b, ext_a, ext_b_en} = {8'h00, 8'h00, 8'hFF};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk("pull_up_por", b_pu, 0);
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 0);
            chk("reset_value", rd, rv[i]);
        end
        $display("reset test done");
        foreach (rows[i]) begin
            ext_b <= rows[i].ext;
            apb(1'b1, ADDR_ANALOG_SELECT_LOW_H, rows[i].ana);
            apb(1'b1, ADDR_DIR_B, rows[i].dir);
            apb(1'b1, ADDR_PORT_B, rows[i].lat);
            tick(3);
            apb(1'b0, ADDR_PORT_B, 0);
            chk("port_b_read", rd, rows[i].rd);
            chk("port_b_oe_n", b_oe_n, rows[i].dir);
            chk("port_b_out", b_out, rows[i].lat);
        end
        $display("table test done");
        apb(1'b1, ADDR_OPTION, 32'h0000_007F);
        chk("pull_up_out", b_pu, 8'h0F);
        apb(1'b1, ADDR_OPTION, 32'h0000_00FF);
        chk("pull_up_off", b_pu, 8'h00);
        $display("pull-up test done");
        ext_b <= 8'h00;
        apb(1'b1, ADDR_DIR_B, 32'h0000_00FF);
        apb(1'b1, ADDR_ANALOG_SELECT_LOW_H, 0);
        tick(3);
        apb(1'b0, ADDR_PORT_B, 0);
        apb(1'b1, ADDR_CHG_EN, 32'h0000_0001);
        apb(1'b1, ADDR_INT_CTRL, 32'h0000_0008);
        ext_b <= 8'h02;
        tick(5);
        chk("flag_masked", flag, 0);
        apb(1'b0, ADDR_PORT_B, 0);
        ext_b <= 8'h03;
        tick(5);
        chk("flag_set", flag, 1);
        chk("wake", wake, 1);
        apb(1'b1, ADDR_INT_CTRL, 32'h0000_0008);
        chk("flag_clear_lost", flag, 1);
        soft_reset_n <= 1'b0;
        tick(1);
        soft_reset_n <= 1'b1;
        tick(1);
        chk("flag_soft_reset", flag, 1);
        apb(1'b1, ADDR_ANALOG_SELECT_LOW_H, 0);
        apb(1'b0, ADDR_PORT_B, 0);
        apb(1'b1, ADDR_INT_CTRL, 0);
        chk("flag_cleared", flag, 0);
        $display("change test done");
        // charge pin high as output, release to input, arm, then let it fall
        ext_b <= 8'h01;
        apb(1'b1, ADDR_PORT_B, 32'h0000_0001);
        apb(1'b1, ADDR_DIR_B, 32'h0000_00FE);
        apb(1'b1, ADDR_DIR_B, 32'h0000_00FF);
        tick(3);
        apb(1'b0, ADDR_PORT_B, 0);
        apb(1'b1, ADDR_INT_CTRL, 32'h0000_0008);
        chk("wake_idle", wake, 0);
        ext_b <= 8'h00;
        tick(5);
        chk("wake_on_fall", wake, 1);
        apb(1'b0, ADDR_PORT_B, 0);
        apb(1'b1, ADDR_INT_CTRL, 0);
        chk("wake_cleared", wake, 0);
        $display("wake test done");
        clk_en <= 1'b0;
        apb(1'b1, ADDR_DIR_B, 0);
        clk_en <= 1'b1;
        apb(1'b0, ADDR_DIR_B, 0);
        chk("frozen_write", rd, 32'h0000_00FF);
        apb(1'b1, ADDR_DIR_A, 0);
        chk("port_a_oe_n", a_oe_n, 8'h08);
        apb(1'b1, ADDR_PORT_A, 32'h0000_00A5);
        chk("port_a_out", a_out, 8'hA5);
        apb(1'b0, ADDR_PORT_A, 0);
        chk("port_a_read", rd, 0);
        apb(1'b0, 12'h040, 0);
        chk("unmapped_read", rd, 0);
        chk("bus_status", {pready, pslverr}, 2'b10);
        $display("misc test done");
        wrap_up();
    end
endmodule : testbench
